// ---- hw/conv_sync_top.sv ----
// Conversion sync, overrange flags and APB registers
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "conv_sync_consts.svh"

// How it works
// RQ1: Software clears both pin enable bits so the pins serve as sync and clock.
// RQ2: Software sets sync mode and external clock select to use checking.
// RQ3: In sync mode the cycles from ready assertion to next sync rise are recorded.
// RQ4: Later sync rises re-measure; a drift beyond one restarts and flushes the filter.
// RQ5: After a flush no result is valid until the full filter latency passes.
// RQ6: Sync rises before the first falling edge of ready are ignored.
// RQ7: The first sync rise after a ready assertion sets the reference.
// RQ8: Filter overflow sets the digital flag and saturates the word.
// RQ9: Modulator overrange sets the analog flag together with the word update.
// RQ10: The analog flag always matches the word currently held.
// RQ11: The bit stream passes a fifth order sinc decimator to 24-bit words.
// RQ12: Software clears the regulator enable when the core is fed externally.
// RQ13: A configuration bit switches the fault test currents on and off.
// RQ14: Sync edges are detected on the clock so counting is single-domain.
module conv_sync_top #(
   parameter int CW = 20
) (
   input  wire logic          pclk,            // 100 MHz clock
   input  wire logic          presetn,         // Async reset, low
   input  wire logic          psel,            // APB select
   input  wire logic          penable,         // APB enable
   input  wire logic          pwrite,          // APB direction
   input  wire logic [11:0]   paddr,           // APB byte address
   input  wire logic [31:0]   pwdata,          // APB write data
   output logic [31:0]        prdata,          // APB read data
   output logic               pready,          // APB ready
   output logic               pslverr,         // APB error
   input  wire logic          sync_input_pin,  // Sync pulse
   input  wire logic          mod_bit,         // Modulator bit stream
   input  wire logic          mod_over,        // Modulator overrange
   output logic               result_ready_n,  // Data ready, low
   output logic               fault_current_enable, // Test currents
   output logic               core_regulator_enable, // Regulator on
   output logic               external_clock_select, // Ext clock
   output logic               irq              // Interrupt level
);
   // ------------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------------
   conv_sync_pkg::config_s     cfg, next_cfg;
   conv_sync_pkg::result_s     res;
   conv_sync_pkg::sync_state_e st, next_st;
   logic [CW-1:0]              ref_cnt, next_ref_cnt;
   logic [`IRQ_BITS-1:0]       irq_st, next_irq_st;
   logic [`IRQ_BITS-1:0]       irq_mask, next_irq_mask;
   logic [`IRQ_BITS-1:0]       ev;
   logic                       rdy_n, next_rdy_n;
   logic                       seen_ready, next_seen_ready;
   logic                       flush, next_flush;
   logic                       locked;
   logic                       res_valid, rise, wr, rd;
   logic [CW-1:0]              count;
   logic [CW:0]                delta;
   logic                       sync_active, drift;

   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;

   // ------------------------------------------------------------------
   // Datapath blocks
   // ------------------------------------------------------------------
   sinc5_decim u_decim (
      .pclk      (pclk),
      .presetn   (presetn),
      .flush     (flush),
      .mod_bit   (mod_bit),
      .mod_over  (mod_over),
      .result    (res),
      .res_valid (res_valid)
   );

   sync_edge_counter #(.CW(CW)) u_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .sync_in (sync_input_pin),
      .restart (res_valid),
      .rise    (rise),
      .count   (count)
   );

   // Checking only counts when the host set up both pins and modes
   assign sync_active = cfg.sync_mode & cfg.ext_clk_sel // RQ2
                        & ~cfg.pin0_en & ~cfg.pin1_en; // RQ1
   assign delta = (count >= ref_cnt) ? {1'b0, count - ref_cnt}
                                     : {1'b0, ref_cnt - count};
   assign drift = delta > (CW+1)'(1); // RQ4
   assign locked = (st == conv_sync_pkg::SY_LOCK);

   // ------------------------------------------------------------------
   // Sync tracking
   // ------------------------------------------------------------------
   always_comb begin
      next_st         = st;
      next_ref_cnt    = ref_cnt;
      next_flush      = 1'b0;
      next_rdy_n      = rdy_n;
      next_seen_ready = seen_ready | res_valid;
      if (res_valid)
         next_rdy_n = 1'b0;
      else if (rd && paddr == `OFS_DATA)
         next_rdy_n = 1'b1;
      if (!sync_active) begin
         next_st = conv_sync_pkg::SY_IDLE;
      end else begin
         unique case (st)
            conv_sync_pkg::SY_IDLE:
               next_st = conv_sync_pkg::SY_ARMED;
            conv_sync_pkg::SY_ARMED: begin
               // Pulses before first ready fall are dropped RQ6
               if (seen_ready)
                  next_st = conv_sync_pkg::SY_MEAS;
            end
            conv_sync_pkg::SY_MEAS: begin
               if (rise) begin
                  next_ref_cnt = count; // RQ3
                  next_st      = conv_sync_pkg::SY_LOCK; // RQ7
               end
            end
            conv_sync_pkg::SY_LOCK: begin
               if (rise && drift) begin
                  next_flush      = 1'b1; // RQ4
                  next_seen_ready = 1'b0;
                  next_rdy_n      = 1'b1;
                  next_st         = conv_sync_pkg::SY_ARMED;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st         <= conv_sync_pkg::SY_IDLE;
         ref_cnt    <= '0;
         flush      <= 1'b0;
         rdy_n      <= 1'b1;
         seen_ready <= 1'b0;
      end else begin
         st         <= next_st;
         ref_cnt    <= next_ref_cnt;
         flush      <= next_flush;
         rdy_n      <= next_rdy_n;
         seen_ready <= next_seen_ready;
      end
   end

   assign result_ready_n        = rdy_n;
   assign fault_current_enable  = cfg.fault_cur_en; // RQ13
   assign core_regulator_enable = cfg.regulator_en;
   assign external_clock_select = cfg.ext_clk_sel;

   // ------------------------------------------------------------------
   // Configuration and interrupt registers
   // ------------------------------------------------------------------
   assign ev = {res_valid & res.ana_over, res_valid & res.dig_over, next_flush,
                res_valid};

   always_comb begin
      next_cfg      = cfg;
      next_irq_mask = irq_mask;
      next_irq_st   = irq_st;
      if (wr) begin
         unique case (paddr)
            `OFS_CONTROL_TWO: begin
               next_cfg.ext_clk_sel  = pwdata[`BIT_EXT_CLK_SEL];
               next_cfg.regulator_en = pwdata[`BIT_REG_EN];
            end
            `OFS_CONTROL_THREE: begin
               next_cfg.sync_mode    = pwdata[`BIT_SYNC_MODE];
               next_cfg.fault_cur_en = pwdata[`BIT_FAULT_CUR];
            end
            `OFS_PIN_CTRL: begin
               next_cfg.pin0_en = pwdata[`BIT_PIN0_EN];
               next_cfg.pin1_en = pwdata[`BIT_PIN1_EN];
            end
            `OFS_IRQ_STATUS:
               next_irq_st = irq_st & ~pwdata[`IRQ_BITS-1:0];
            `OFS_IRQ_MASK:
               next_irq_mask = pwdata[`IRQ_BITS-1:0];
            default: ;
         endcase
      end
      // Set wins over a simultaneous clear
      next_irq_st = next_irq_st | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {cfg.regulator_en, cfg.ext_clk_sel} <= `RST_CONTROL_TWO;
         {cfg.sync_mode, cfg.fault_cur_en}   <= `RST_CONTROL_THREE;
         {cfg.pin0_en, cfg.pin1_en}          <= `RST_PIN_CTRL;
         irq_st   <= '0;
         irq_mask <= '0;
      end else begin
         cfg      <= next_cfg;
         irq_st   <= next_irq_st;
         irq_mask <= next_irq_mask;
      end
   end

   assign irq = |(irq_st & irq_mask);

   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   always_comb begin
      prdata  = '0;
      pslverr = 1'b0;
      unique case (paddr)
         `OFS_CONTROL_TWO: begin
            prdata[`BIT_EXT_CLK_SEL] = cfg.ext_clk_sel;
            prdata[`BIT_REG_EN]      = cfg.regulator_en;
         end
         `OFS_CONTROL_THREE: begin
            prdata[`BIT_SYNC_MODE] = cfg.sync_mode;
            prdata[`BIT_FAULT_CUR] = cfg.fault_cur_en;
         end
         `OFS_PIN_CTRL: begin
            prdata[`BIT_PIN0_EN] = cfg.pin0_en;
            prdata[`BIT_PIN1_EN] = cfg.pin1_en;
         end
         `OFS_STATUS: begin
            prdata[`BIT_ST_DIG_OVER] = res.dig_over;
            prdata[`BIT_ST_ANA_OVER] = res.ana_over; // RQ10
            prdata[`BIT_ST_LOCKED] = locked;
            prdata[`BIT_ST_VALID]  = ~rdy_n;
         end
         `OFS_DATA:       prdata[23:0] = res.word;
         `OFS_IRQ_STATUS: prdata[`IRQ_BITS-1:0] = irq_st;
         `OFS_IRQ_MASK:   prdata[`IRQ_BITS-1:0] = irq_mask;
         `OFS_SYNC_COUNT: prdata[CW-1:0] = ref_cnt;
         default:         pslverr = psel & penable;
      endcase
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   drift_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
      (locked && sync_active && rise && drift) |=> flush) // RQ4
      else $error("drift did not flush filter");
   no_drift_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      (locked && sync_active && rise && !drift) |=> !flush && locked) // RQ4
      else $error("in-limit sync disturbed conversion");
   early_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st == conv_sync_pkg::SY_ARMED && !seen_ready) |=> !locked) // RQ6
      else $error("sync accepted before ready");
   ref_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st == conv_sync_pkg::SY_MEAS && sync_active && rise)
      |=> locked && ref_cnt == $past(count)) // RQ3
      else $error("reference count not captured");
   ready_on_result_a: assert property (@(posedge pclk) disable iff (!presetn)
      res_valid |=> !result_ready_n) // RQ7
      else $error("ready not asserted on result");
   sat_value_a: assert property (@(posedge pclk) disable iff (!presetn)
      res.dig_over |-> (res.word == `SAT_POS || res.word == `SAT_NEG)) // RQ8
      else $error("overflow without saturated word");
   flag_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
      !res_valid |-> $stable(res.ana_over) && $stable(res.word)) // RQ10
      else $error("flag moved without a result");
   fault_cur_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `OFS_CONTROL_THREE)
      |=> fault_current_enable == $past(pwdata[`BIT_FAULT_CUR])) // RQ13
      else $error("fault current enable not applied");
endmodule // conv_sync_top

// ---- hw/conv_sync_consts.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef CONV_SYNC_CONSTS_SVH
`define CONV_SYNC_CONSTS_SVH

// ------------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------------
`define OFS_CONTROL_TWO    12'h000
`define OFS_CONTROL_THREE  12'h004
`define OFS_PIN_CTRL       12'h008
`define OFS_STATUS         12'h00c
`define OFS_DATA           12'h010
`define OFS_IRQ_STATUS     12'h014
`define OFS_IRQ_MASK       12'h018
`define OFS_SYNC_COUNT     12'h01c

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define BIT_EXT_CLK_SEL    0
`define BIT_REG_EN         1
`define BIT_SYNC_MODE      0
`define BIT_FAULT_CUR      1
`define BIT_PIN0_EN        0
`define BIT_PIN1_EN        1
`define BIT_ST_DIG_OVER    0
`define BIT_ST_ANA_OVER    1
`define BIT_ST_LOCKED      2
`define BIT_ST_VALID       3
`define IRQ_READY          0
`define IRQ_RESYNC         1
`define IRQ_DIG_OVER       2
`define IRQ_ANA_OVER       3
`define IRQ_BITS           4

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_CONTROL_TWO    2'h2
`define RST_CONTROL_THREE  2'h0
`define RST_PIN_CTRL       2'h0

// ------------------------------------------------------------------
// Saturation words and timing
// ------------------------------------------------------------------
`define SAT_POS            24'h7fffff
`define SAT_NEG            24'h800000
`define DEC_RATIO          16
`define SINC_ORDER         5

`endif

// ---- hw/conv_sync_pkg.sv ----
// Types shared by the conversion sync design
package conv_sync_pkg;
   typedef enum logic [1:0] {
      SY_IDLE  = 2'b00,
      SY_ARMED = 2'b01,
      SY_MEAS  = 2'b10,
      SY_LOCK  = 2'b11
   } sync_state_e;

   typedef struct packed {
      logic [23:0] word;
      logic        dig_over;
      logic        ana_over;
   } result_s;

   typedef struct packed {
      logic        ext_clk_sel;
      logic        regulator_en;
      logic        sync_mode;
      logic        fault_cur_en;
      logic        pin0_en;
      logic        pin1_en;
   } config_s;
endpackage

// ---- hw/sinc5_decim.sv ----
// Fifth order sinc decimator with saturation to a 24-bit word
`timescale 1ns/100ps
`include "conv_sync_consts.svh"
module sinc5_decim #(
   parameter int RATIO = `DEC_RATIO,
   parameter int ORDER = `SINC_ORDER
) (
   input  wire logic                     pclk,      // Clock
   input  wire logic                     presetn,   // Async reset
   input  wire logic                     flush,     // Filter reset pulse
   input  wire logic                     mod_bit,   // Modulator bit
   input  wire logic                     mod_over,  // Analog overrange
   output conv_sync_pkg::result_s        result,    // Registered result
   output logic                          res_valid  // Result pulse
);
   localparam int AW = 32;
   localparam int DW = $clog2(RATIO);
   localparam int LW = $clog2(ORDER + 1);

   logic [AW-1:0] integ [ORDER];
   logic [AW-1:0] next_integ [ORDER];
   logic [AW-1:0] comb_d [ORDER];
   logic [AW-1:0] next_comb_d [ORDER];
   logic [AW-1:0] diff [ORDER+1];
   logic [DW-1:0] phase, next_phase;
   logic [LW-1:0] settle, next_settle;
   logic          aor_acc, next_aor_acc;
   conv_sync_pkg::result_s next_result;
   logic          next_res_valid;
   logic signed [AW-1:0] centred;
   logic          dec_tick;

   assign dec_tick = (phase == DW'(RATIO - 1));
   assign diff[0]  = integ[ORDER-1];

   // ------------------------------------------------------------------
   // Integrator and comb chains
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < ORDER; g++) begin : g_stage
         always_comb begin
            next_integ[g]  = integ[g];
            next_comb_d[g] = comb_d[g];
            if (flush) begin
               next_integ[g]  = '0;
               next_comb_d[g] = '0;
            end else begin
               next_integ[g] = integ[g] + ((g == 0) ? AW'(mod_bit)
                                                    : integ[g-1]);
               if (dec_tick)
                  next_comb_d[g] = diff[g];
            end
         end
         assign diff[g+1] = diff[g] - comb_d[g];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               integ[g]  <= '0;
               comb_d[g] <= '0;
            end else begin
               integ[g]  <= next_integ[g];
               comb_d[g] <= next_comb_d[g];
            end
         end
      end
   endgenerate

   // Gain is RATIO^ORDER; centre the unipolar count to two's complement
   assign centred = signed'(diff[ORDER]) - signed'(AW'(RATIO ** ORDER / 2));

   // ------------------------------------------------------------------
   // Output word, overrange and latency hold-off
   // ------------------------------------------------------------------
   always_comb begin
      next_phase     = flush ? '0 : phase + 1'b1;
      next_settle    = settle;
      next_aor_acc   = flush ? 1'b0 : (aor_acc | mod_over);
      next_result    = result;
      next_res_valid = 1'b0;
      if (!flush && dec_tick) begin
         next_aor_acc = 1'b0;
         if (settle != LW'(ORDER))
            next_settle = settle + 1'b1;
         else begin
            // Suppress results until the full latency has passed RQ5
            next_res_valid = 1'b1;
            // Word and both flags update together RQ10
            next_result.ana_over = aor_acc | mod_over; // RQ9
            next_result.dig_over = 1'b0;
            if (centred > signed'(AW'(8388607))) begin
               next_result.word     = `SAT_POS; // RQ8
               next_result.dig_over = 1'b1; // RQ8
            end else if (centred < -signed'(AW'(8388608))) begin
               next_result.word     = `SAT_NEG; // RQ8
               next_result.dig_over = 1'b1; // RQ8
            end else
               next_result.word = centred[23:0]; // RQ11
         end
      end
      if (flush)
         next_settle = '0; // RQ5
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase     <= '0;
         settle    <= '0;
         aor_acc   <= 1'b0;
         result    <= '0;
         res_valid <= 1'b0;
      end else begin
         phase     <= next_phase;
         settle    <= next_settle;
         aor_acc   <= next_aor_acc;
         result    <= next_result;
         res_valid <= next_res_valid;
      end
   end

   no_early_result_a: assert property (@(posedge pclk) disable iff (!presetn)
      flush |=> !res_valid [*8]) // RQ5
      else $error("result valid too soon after filter reset");
endmodule // sinc5_decim

// ---- hw/sync_edge_counter.sv ----
// Rising edge detector and cycle counter for the sync pin
`timescale 1ns/100ps
module sync_edge_counter #(
   parameter int CW = 20
) (
   input  wire logic          pclk,     // Clock
   input  wire logic          presetn,  // Async reset
   input  wire logic          sync_in,  // Sync pin level
   input  wire logic          restart,  // Reload the count to one
   output logic               rise,     // Rising edge pulse
   output logic [CW-1:0]      count     // Cycles since restart
);
   logic          sync_d, next_sync_d;
   logic [CW-1:0] next_count;

   // Pin is already synchronous; one stage for edge detection RQ14
   assign rise = sync_in & ~sync_d; // RQ14

   always_comb begin
      next_sync_d = sync_in;
      next_count  = restart ? CW'(1) : count + CW'(count != '1);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_d <= 1'b0;
         count  <= '0;
      end else begin
         sync_d <= next_sync_d;
         count  <= next_count;
      end
   end
endmodule // sync_edge_counter

// ---- tb/sync_host_model.sv ----
// Host-side model that issues a periodic sync pulse train
`timescale 1ns/100ps
module sync_host_model (
   input  wire logic        pclk,           // Clock
   input  wire logic        presetn,        // Async reset, low
   input  wire logic        run,            // Pulse train on
   input  wire logic [15:0] period,         // Cycles per pulse
   output logic             sync_input_pin  // Sync pulse
);
   int cnt;

   initial sync_input_pin = 1'b0;

   // Launched on the clock, four cycles wide; period may change per pulse
   always @(posedge pclk) begin
      if (!presetn || !run) begin
         cnt <= 0;
         sync_input_pin <= 1'b0;
      end else begin
         sync_input_pin <= (cnt < 4);
         cnt <= (cnt >= int'(period) - 1) ? 0 : cnt + 1;
      end
   end
endmodule // sync_host_model

// ---- tb/conv_sync_and_overrange_test.sv ----
// Self-checking bench for the conversion sync and overrange block
`timescale 1ns/100ps
`include "conv_sync_consts.svh"
module conversion_sync_and_overrange_test;
   localparam logic [31:0] ALL = 32'hffffffff;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        sync_input_pin, mod_bit, mod_over, result_ready_n, irq;
   logic        fault_current_enable, core_regulator_enable;
   logic        external_clock_select, run;
   logic [15:0] period;
   int          failures = 0;
   int          check_count = 0;
   int          d;

   conv_sync_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sync_input_pin, .mod_bit,
      .mod_over, .result_ready_n, .fault_current_enable,
      .core_regulator_enable, .external_clock_select, .irq);
   sync_host_model i_host (.pclk, .presetn, .run, .period, .sync_input_pin);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ---------------------------------------------------------------
   // Bus and check tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Called just after an edge; idles one cycle so psel never toggles twice
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      if (n >= 20) failures++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                     input logic [31:0] m);
      xfer(1'b0, a, 32'h0);
      chk(q & m, exp);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask

   task automatic wait_sync();
      logic prev;
      int   n;
      n = 0;
      prev = sync_input_pin;
      @(posedge pclk);
      while (!(sync_input_pin === 1'b1 && prev === 1'b0) && n < 400) begin
         prev = sync_input_pin;
         @(posedge pclk);
         n++;
      end
      if (n >= 400) failures++;
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Whole run is under two thousand cycles; ten times that is a hang
   initial begin
      #200000;
      failures++;
      final_report();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, run, mod_over} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      mod_bit = 1'b1;
      period = 16'd160;
      cyc(4);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({result_ready_n, core_regulator_enable, external_clock_select,
           fault_current_enable, irq}, 32'h18);
      rd(`OFS_CONTROL_TWO, 32'h2, ALL);
      rd(`OFS_CONTROL_THREE, 32'h0, ALL);
      rd(`OFS_PIN_CTRL, 32'h0, ALL);
      rd(12'h020, 32'h0, ALL);
      chk(e, 32'h1);
      xfer(1'b1, `OFS_PIN_CTRL, 32'h0);
      xfer(1'b1, `OFS_CONTROL_TWO, 32'h3);
      xfer(1'b1, `OFS_CONTROL_THREE, 32'h3);
      chk({external_clock_select, fault_current_enable}, 32'h3);
      // First pulse lands before any result and must not lock
      run <= 1'b1;
      cyc(20);
      rd(`OFS_SYNC_COUNT, 32'h0, ALL);
      rd(`OFS_STATUS, 32'h0, 32'hc);
      cyc(500);
      rd(`OFS_STATUS, 32'hc, 32'hf);
      rd(`OFS_DATA, 32'h00080000, ALL);
      rd(`OFS_IRQ_STATUS, 32'h0, 32'h2);
      xfer(1'b0, `OFS_SYNC_COUNT, 32'h0);
      chk(q >= 1 && q <= 16, 32'h1);
      // Nudge one pulse by one cycle away from the count wrap
      d = (q < 8) ? 1 : -1;
      wait_sync();
      period <= 16'(160 + d);
      wait_sync();
      period <= 16'd160;
      wait_sync();
      cyc(4);
      rd(`OFS_IRQ_STATUS, 32'h0, 32'h2);
      xfer(1'b1, `OFS_IRQ_MASK, 32'h2);
      wait_sync();
      period <= 16'd165;
      wait_sync();
      period <= 16'd160;
      cyc(4);
      chk({result_ready_n, irq}, 32'h3);
      rd(`OFS_STATUS, 32'h0, 32'h8);
      xfer(1'b1, `OFS_IRQ_STATUS, 32'h2);
      chk(irq, 32'h0);
      rd(`OFS_IRQ_STATUS, 32'h0, 32'h2);
      cyc(60);
      chk(result_ready_n, 32'h1);
      mod_over <= 1'b1;
      cyc(60);
      rd(`OFS_STATUS, 32'h2, 32'h3);
      rd(`OFS_DATA, 32'h00080000, ALL);
      mod_over <= 1'b0;
      cyc(40);
      rd(`OFS_STATUS, 32'h0, 32'h3);
      mod_bit <= 1'b0;
      cyc(120);
      rd(`OFS_DATA, 32'h00f80000, ALL);
      rd(`OFS_STATUS, 32'h0, 32'h1);
      xfer(1'b1, `OFS_IRQ_MASK, 32'h1);
      chk(irq, 32'h1);
      xfer(1'b1, `OFS_IRQ_MASK, 32'h0);
      chk(irq, 32'h0);
      xfer(1'b1, `OFS_CONTROL_TWO, 32'h1);
      xfer(1'b1, `OFS_CONTROL_THREE, 32'h1);
      chk({core_regulator_enable, fault_current_enable,
           external_clock_select}, 32'h1);
      rd(`OFS_CONTROL_TWO, 32'h1, ALL);
      final_report();
   end
endmodule // conversion_sync_and_overrange_test
